// ===== bit_branch_defs.svh
// What this block does
// - A relative jump loads the program counter with the already-incremented address plus twice its signed 11-bit offset.
// - A relative jump is one word and two instruction cycles: the counter is written in the last phase and the next cycle is a no-operation.
// - A set-bit forces the chosen bit of the chosen file register to one and touches no status flag.
// - The set-bit opcode is top nibble 1000, bit index, access flag and file address, read in phase two, processed in three, written in four.
// - With the access flag at zero the file address is resolved inside the fixed access bank.
// - With the access flag at one the bank select register picks the general file bank.
// - With the extended set on and the access flag at zero, file addresses up to 5Fh use indexed literal offset addressing.
// - A skip-if-set test skips the next instruction when the tested bit is one.
// - A skip discards the fetched next instruction and runs a no-operation instead, two cycles, or three if that instruction is two words.
//
// Purpose: constants of the branch and bit decode block
// Assumes: one clock edge per instruction phase
// Notes: widths are fixed
`ifndef BIT_BRANCH_DEFS_SVH
`define BIT_BRANCH_DEFS_SVH

// =============================================================
// opcode fields
`define OPC_JUMP_HI 5'h1a
`define OPC_SET_BIT 4'h8
`define OPC_SKIP_CLR 4'hb
`define OPC_SKIP_SET 4'ha
`define NOP_WORD 16'h0000

// =============================================================
// addressing
`define INDEXED_MAX 8'h5f
`define ACCESS_SPLIT 8'h80
`define ACCESS_LOW_PAGE 4'h0
`define ACCESS_HIGH_PAGE 4'hf

// =============================================================
// reset values
`define PC_RESET 21'h00_0000
`define ADDR_RESET 12'h000
`define BYTE_RESET 8'h00
`define OFFSET_RESET 11'h000
`define BIT_SEL_RESET 3'h0

`endif

// ===== bit_branch_pkg.sv
// Purpose: types of the branch and bit decode block
// Assumes: bit_branch_defs.svh included alongside
// Notes: state of the core module is one packed struct
package bit_branch_pkg;

   // =============================================================
   // sequencer states, one-hot
   typedef enum logic [2:0] {
      st_exec = 3'b001,
      st_nop = 3'b010,
      st_nop2 = 3'b100
   } seq_state_e;

   // =============================================================
   // decoded instruction classes
   typedef enum logic [2:0] {
      op_none = 3'h0,
      relative_jump_op = 3'h1,
      set_bit_op = 3'h2,
      skip_if_clear_op = 3'h3,
      skip_if_set_op = 3'h4
   } op_class_e;

   typedef struct packed {
      seq_state_e state;
      op_class_e op;
      logic [10:0] offset;
      logic [2:0] bit_sel;
      logic [7:0] rdata;
      logic [11:0] file_addr;
      logic file_rd;
      logic file_wr;
      logic [7:0] file_wdata;
      logic pc_load;
      logic [20:0] pc_value;
      logic discard_fetch;
      logic nop_cycle;
      logic instr_done;
   } core_s;

endpackage : bit_branch_pkg

// ===== phase_gen.sv
// Purpose: four-phase instruction cycle enables
// Assumes: one phase per ref_clk edge
// Notes: phase[0] is the decode phase, high first after reset
`timescale 1ns/10ps
module phase_gen #(
   parameter int PHASES = 4
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // one-hot phase enables
   output logic [PHASES-1:0] phase
);

   // =============================================================
   // rotating one-hot ring, no decoder needed downstream
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= {{(PHASES-1){1'b0}}, 1'b1};
      end else begin
         phase <= {phase[PHASES-2:0], phase[PHASES-1]};
      end
   end

endmodule : phase_gen

// ===== bit_branch_decode.sv
// Purpose: decode and execute relative jump, set-bit and bit-test-skip
// Assumes: instr_word stable during phase one, file_rdata valid while file_rd is high
// Notes: other opcodes pass through as single cycles with no effect
//    the fetch side must put a new word up before each decode phase; a word
//    left standing after a cycle is decoded and run again
//    the indexed mode only adds the literal to index_base; the full indexed
//    path lives outside this block
//    no status flag path exists here, so none of these instructions alters one
//    a two-word skip relies on next_two_word being right in the last phase
`timescale 1ns/10ps
`include "bit_branch_defs.svh"
module bit_branch_decode (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // fetch side
   input wire logic [15:0] instr_word,
   input wire logic next_two_word,
   input wire logic [20:0] pc_in,
   // bank and mode
   input wire logic [3:0] bank_select_reg,
   input wire logic ext_mode,
   input wire logic [11:0] index_base,
   // file register path
   input wire logic [7:0] file_rdata,
   output logic [11:0] file_addr,
   output logic file_rd,
   output logic file_wr,
   output logic [7:0] file_wdata,
   // program counter
   output logic pc_load,
   output logic [20:0] pc_value,
   // pipeline control
   output logic discard_fetch,
   output logic nop_cycle,
   output logic instr_done,
   output logic [3:0] phase
);
   import bit_branch_pkg::*;

   // =============================================================
   // state copy and its next value
   core_s cur;
   core_s nxt;
   // phase ring from the enable generator
   logic [3:0] ph;
   // operand fields and resolved address of the word in decode
   logic [7:0] f_field;
   logic a_flag;
   logic [11:0] dec_addr;
   // bit test helpers on the captured byte
   logic [7:0] bit_mask;
   logic bit_val;
   logic skip;

   // =============================================================
   // phase enables
   phase_gen #(.PHASES(4)) i_phase_gen (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .phase(ph)
   );

   // =============================================================
   // file address resolution from the live instruction word
   assign f_field = instr_word[7:0];
   assign a_flag = instr_word[8];
   always_comb begin
      // banked by default; the access flag at zero overrides it
      dec_addr = {bank_select_reg, f_field};
      if (!a_flag) begin
         if (ext_mode && (f_field <= `INDEXED_MAX)) begin
            // only the base plus literal; the full indexed path lives elsewhere
            dec_addr = index_base + {4'h0, f_field};
         end else if (f_field < `ACCESS_SPLIT) begin
            dec_addr = {`ACCESS_LOW_PAGE, f_field};
         end else begin
            dec_addr = {`ACCESS_HIGH_PAGE, f_field};
         end
      end
   end

   // =============================================================
   // bit helpers on the captured read data
   assign bit_mask = 8'h01 << cur.bit_sel;
   assign bit_val = |(cur.rdata & bit_mask);
   // the skip sense flips between the two test opcodes
   assign skip = ((cur.op == skip_if_set_op) && bit_val)
      || ((cur.op == skip_if_clear_op) && !bit_val);

   // =============================================================
   // next state; pulses default low so each lasts one phase
   always_comb begin
      nxt = cur;
      nxt.file_rd = 1'b0;
      nxt.file_wr = 1'b0;
      nxt.pc_load = 1'b0;
      nxt.discard_fetch = 1'b0;
      nxt.instr_done = 1'b0;
      // one phase per clock; the state only moves in the last phase of a cycle
      case (cur.state)
         st_exec: begin
            nxt.nop_cycle = 1'b0;
            if (ph[0]) begin
               // decode phase
               nxt.bit_sel = instr_word[11:9];
               nxt.offset = instr_word[10:0];
               nxt.file_addr = dec_addr;
               if (instr_word[15:11] == `OPC_JUMP_HI) begin
                  nxt.op = relative_jump_op;
               end else if (instr_word[15:12] == `OPC_SET_BIT) begin
                  nxt.op = set_bit_op;
                  nxt.file_rd = 1'b1;
               end else if (instr_word[15:12] == `OPC_SKIP_CLR) begin
                  nxt.op = skip_if_clear_op;
                  nxt.file_rd = 1'b1;
               end else if (instr_word[15:12] == `OPC_SKIP_SET) begin
                  nxt.op = skip_if_set_op;
                  nxt.file_rd = 1'b1;
               end else begin
                  // any other opcode runs one cycle with no effect
                  nxt.op = op_none;
               end
            end else if (ph[1]) begin
               // read phase: capture the file byte
               nxt.rdata = file_rdata;
            end else if (ph[2]) begin
               // process phase: results go out in phase four
               case (cur.op)
                  relative_jump_op: begin
                     nxt.pc_load = 1'b1;
                     nxt.pc_value = pc_in + {{9{cur.offset[10]}}, cur.offset, 1'b0};
                  end
                  set_bit_op: begin
                     // status flags have no path out of this block
                     nxt.file_wr = 1'b1;
                     nxt.file_wdata = cur.rdata | bit_mask;
                  end
                  skip_if_set_op, skip_if_clear_op: begin
                     nxt.discard_fetch = skip;
                  end
                  default: begin
                     nxt.file_wdata = cur.file_wdata;
                  end
               endcase
            end else begin
               // last phase: pick the following cycle
               if (cur.op == relative_jump_op) begin
                  nxt.state = st_nop;
                  nxt.nop_cycle = 1'b1;
               end else if ((cur.op == skip_if_set_op || cur.op == skip_if_clear_op) && skip) begin
                  nxt.state = next_two_word ? st_nop2 : st_nop;
                  nxt.nop_cycle = 1'b1;
               end else begin
                  // nothing forced: retire now
                  nxt.instr_done = 1'b1;
               end
               nxt.op = op_none;
            end
         end
         st_nop2: begin
            // second word of a skipped two-word instruction
            if (ph[3]) begin
               nxt.state = st_nop;
            end
         end
         st_nop: begin
            // forced no-op; the standing word is ignored until this cycle ends
            if (ph[3]) begin
               nxt.state = st_exec;
               nxt.nop_cycle = 1'b0;
               nxt.instr_done = 1'b1;
            end
         end
         default: begin
            // a broken state code falls back to execute rather than hanging
            nxt.state = st_exec;
         end
      endcase
   end

   // =============================================================
   // state register
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         // every field to a constant; the phase ring restarts at decode with it
         cur <= '{
            state: st_exec,
            op: op_none,
            offset: `OFFSET_RESET,
            bit_sel: `BIT_SEL_RESET,
            rdata: `BYTE_RESET,
            file_addr: `ADDR_RESET,
            file_rd: 1'b0,
            file_wr: 1'b0,
            file_wdata: `BYTE_RESET,
            pc_load: 1'b0,
            pc_value: `PC_RESET,
            discard_fetch: 1'b0,
            nop_cycle: 1'b0,
            instr_done: 1'b0
         };
      end else begin
         cur <= nxt;
      end
   end

   // =============================================================
   // outputs straight from the state flops
   // file register path
   assign file_addr = cur.file_addr;
   assign file_rd = cur.file_rd;
   assign file_wr = cur.file_wr;
   assign file_wdata = cur.file_wdata;
   // program counter
   assign pc_load = cur.pc_load;
   assign pc_value = cur.pc_value;
   // pipeline control
   assign discard_fetch = cur.discard_fetch;
   assign nop_cycle = cur.nop_cycle;
   assign instr_done = cur.instr_done;
   // the ring is a flop inside the generator, so this is still registered
   assign phase = ph;

endmodule : bit_branch_decode

// ===== bb_check_sva.sv
// Purpose: port checks of the branch and bit decode block
// Assumes: one ref_clk edge per phase
// Notes: $past depths follow the four-clock walk
`timescale 1ns/10ps
module bb_check (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // inputs of the block
   input wire logic [15:0] instr_word,
   input wire logic next_two_word,
   input wire logic [20:0] pc_in,
   input wire logic [3:0] bank_select_reg,
   input wire logic ext_mode,
   input wire logic [11:0] index_base,
   input wire logic [7:0] file_rdata,
   // outputs of the block
   input wire logic [11:0] file_addr,
   input wire logic file_rd,
   input wire logic file_wr,
   input wire logic [7:0] file_wdata,
   input wire logic pc_load,
   input wire logic [20:0] pc_value,
   input wire logic discard_fetch,
   input wire logic nop_cycle,
   input wire logic instr_done,
   input wire logic [3:0] phase
);
   // ====
   // decode is three edges before the phase-four strobes
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   AST_PC_TARGET: assert property (pc_load |-> pc_value == $past(pc_in)
      + {{9{$past(instr_word[10], 3)}}, $past(instr_word[10:0], 3), 1'b0}) else $error("bad target");
   AST_JUMP_NOP: assert property (pc_load |=> nop_cycle [*4] ##1
      (instr_done && !nop_cycle)) else $error("jump not two cycles");
   AST_WR_DATA: assert property (file_wr |-> file_wdata ==
      ($past(file_rdata, 2) | (8'h01 << $past(instr_word[11:9], 3)))) else $error("bad set byte");
   AST_BANKED: assert property (file_rd && $past(instr_word[8]) |->
      file_addr == {$past(bank_select_reg), $past(instr_word[7:0])}) else $error("bad bank");
   AST_ACCESS: assert property (file_rd && !$past(instr_word[8]) && !($past(ext_mode)
      && $past(instr_word[7:0]) <= 8'h5f) |-> file_addr ==
      {{4{$past(instr_word[7])}}, $past(instr_word[7:0])}) else $error("bad access bank");
   AST_INDEXED: assert property (file_rd && !$past(instr_word[8]) && $past(ext_mode)
      && $past(instr_word[7:0]) <= 8'h5f |-> file_addr ==
      $past(index_base) + $past(instr_word[7:0])) else $error("bad indexed address");
   AST_SKIP_TEST: assert property (pc_load == 1'b0 && !nop_cycle && $past(file_rd, 2)
      && $past(instr_word[15:13], 3) == 3'b101 |-> discard_fetch == ((($past(file_rdata, 2)
      >> $past(instr_word[11:9], 3)) & 8'h01) != {7'h00, $past(instr_word[12], 3)}))
      else $error("bad skip decision");
   AST_SKIP_NOPS: assert property (discard_fetch |=> nop_cycle [*4] ##1
      (nop_cycle == $past(next_two_word, 5))) else $error("bad skip length");
   AST_PHASE_RING: assert property (1'b1 |=> $onehot(phase)
      && phase == {$past(phase[2:0]), $past(phase[3])}) else $error("phase ring broken");
endmodule : bb_check
bind bit_branch_decode bb_check i_bb_check (.*);

// ===== bb_file_model.sv
// Purpose: file register array beside the decode block
// Assumes: read data is used only while file_rd is high
// Notes: a released read bus shows the inverse of the last byte
`timescale 1ns/10ps
module bb_file_model (
   // clock
   input wire logic ref_clk,
   // file register path
   input wire logic [11:0] file_addr,
   input wire logic file_rd,
   input wire logic file_wr,
   input wire logic [7:0] file_wdata,
   output logic [7:0] file_rdata
);
   logic [7:0] mem [4096];
   logic [7:0] last = 8'h00;
   // ====
   // contents seeded from the address so neighbours differ
   initial begin
      for (int i = 0; i < 4096; i++) mem[i] = 8'(i * 37 + 5);
   end
   // write back and remember the last driven byte
   always @(posedge ref_clk) begin
      if (file_wr) mem[file_addr] <= file_wdata;
      if (file_rd) last <= mem[file_addr];
   end
   // stale data would hide a late read, so the idle bus inverts it
   assign file_rdata = file_rd ? mem[file_addr] : ~last;
endmodule : bb_file_model

// ===== test_branch_and_bit_set_decode.sv
// Purpose: self-checking bench of the branch and bit decode block
// Assumes: inputs change at the falling edge
// Notes: one note per instruction, compared at instr_done
`timescale 1ns/10ps
module test_branch_and_bit_set_decode;
   typedef struct {
      logic rd, wr, ld, disc;
      logic [11:0] addr;
      logic [7:0] wd;
      logic [20:0] pc;
      int nops;
   } note_s;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [15:0] instr_word = 16'h0000;
   logic next_two_word = 1'b0;
   logic [20:0] pc_in = 21'h00_0000;
   logic [3:0] bank_select_reg = 4'h0;
   logic ext_mode = 1'b0;
   logic [11:0] index_base = 12'h000, file_addr;
   logic [7:0] file_rdata, file_wdata, shadow [4096];
   logic file_rd, file_wr, pc_load, discard_fetch, nop_cycle, instr_done;
   logic [20:0] pc_value;
   logic [3:0] phase;
   note_s notes [$];
   note_s seen = '{default: 0};
   note_s want;
   int mismatches = 0;
   int samples_checked = 0;
   int seed = 82083;
   logic [31:0] r;
   bit_branch_decode i_bit_branch_decode (.*);
   bb_file_model i_bb_file_model (.*);
   always #20 ref_clk = ~ref_clk;
   // ====
   task automatic check(string what, logic [31:0] exp, logic [31:0] got);
      samples_checked++;
      if (exp !== got) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic stop_test();
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : stop_test
   // present one word at a decode phase and note what it must do
   task automatic issue(logic [15:0] iw);
      note_s n;
      logic [7:0] f;
      @(negedge ref_clk);
      while (phase !== 4'b0001 || nop_cycle !== 1'b0) @(negedge ref_clk);
      instr_word = iw;
      {bank_select_reg, ext_mode, index_base, next_two_word} = 18'($random(seed));
      pc_in = 21'($random(seed));
      f = iw[7:0];
      n = '{default: 0};
      n.rd = iw[15:14] == 2'b10;
      n.addr = iw[8] ? {bank_select_reg, f} : (ext_mode && f <= 8'h5f) ?
         index_base + {4'h0, f} : {{4{f[7]}}, f};
      n.wr = iw[15:12] == 4'h8;
      n.wd = shadow[n.addr] | (8'h01 << iw[11:9]);
      n.ld = iw[15:11] == 5'h1a;
      n.pc = pc_in + {{9{iw[10]}}, iw[10:0], 1'b0};
      n.disc = iw[15:13] == 3'b101 && shadow[n.addr][iw[11:9]] != iw[12];
      n.nops = (n.ld || n.disc) ? ((n.disc && next_two_word) ? 8 : 4) : 0;
      if (n.wr) shadow[n.addr] = n.wd;
      notes.push_back(n);
   endtask : issue
   // results gathered per instruction, judged when it retires
   always @(negedge ref_clk) begin
      if (rst_n && instr_done === 1'b1) begin
         check("note", 32'h1, 32'(notes.size() != 0));
         want = notes.size() != 0 ? notes.pop_front() : '{default: 0};
         check("file_rd", want.rd, seen.rd);
         check("file_wr", want.wr, seen.wr);
         if (want.rd) check("file_addr", want.addr, seen.addr);
         if (want.wr) check("file_wdata", want.wd, seen.wd);
         check("pc_load", want.ld, seen.ld);
         if (want.ld) check("pc_value", want.pc, seen.pc);
         check("discard_fetch", want.disc, seen.disc);
         check("nop_cycle", want.nops, seen.nops);
         seen = '{default: 0};
      end
      if (file_rd === 1'b1) {seen.rd, seen.addr} = {1'b1, file_addr};
      if (file_wr === 1'b1) {seen.wr, seen.wd} = {1'b1, file_wdata};
      if (pc_load === 1'b1) {seen.ld, seen.pc} = {1'b1, pc_value};
      if (discard_fetch === 1'b1) seen.disc = 1'b1;
      if (nop_cycle === 1'b1) seen.nops++;
   end
   // main sequence: jump with edge offsets, set-bit and both skip tests
   initial begin
      notes.push_back('{default: 0});
      for (int i = 0; i < 4096; i++) shadow[i] = 8'(i * 37 + 5);
      repeat (12) @(negedge ref_clk);
      rst_n = 1'b1;
      for (int i = 0; i < 64; i++) begin
         r = $random(seed);
         case (i % 4)
            0: issue({5'h1a, i == 0 ? 11'h400 : i == 4 ? 11'h3ff : r[10:0]});
            1: issue({4'h8, r[11:0]});
            2: issue({4'ha, r[11:0]});
            default: issue({4'hb, r[11:0]});
         endcase
      end
      for (int k = 0; k < 40 && notes.size() != 0; k++) @(negedge ref_clk);
      check("notes left", 32'h0, 32'(notes.size()));
      stop_test();
   end
   // watchdog well beyond 64 instructions of at most 12 clocks
   initial begin
      repeat (4000) @(posedge ref_clk);
      mismatches++;
      stop_test();
   end
endmodule : test_branch_and_bit_set_decode
